//--- hw/warmup_pkg.sv
// Purpose: shared constants of the oscillator warm-up counter
// Assumes: one aligned 32-bit word per register
// Notes:   only the cascaded warm-up mode is modelled
package warmup_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_LOWER_CTL = 8'h00;
   localparam logic [7:0] OFF_UPPER_CTL = 8'h04;
   localparam logic [7:0] OFF_CMP_LOW   = 8'h08;
   localparam logic [7:0] OFF_CMP_HIGH  = 8'h0c;
   localparam logic [7:0] OFF_SYS_CTL   = 8'h10;
   localparam logic [7:0] OFF_STATUS    = 8'h14;
   // lower timer control fields
   localparam int         SRC_LSB       = 4;
   localparam logic [2:0] SRC_SLOW      = 3'h4;
   localparam logic [2:0] SRC_FAST      = 3'h6;
   localparam logic [2:0] MODE_CASCADE  = 3'h3;
   // upper timer control fields
   localparam int         RUN_BIT       = 3;
   localparam logic [2:0] MODE_WARMUP   = 3'h5;
   localparam int         FF_INIT_BIT   = 7;
   // second system control fields
   localparam int         FAST_EN_BIT   = 7;
   localparam int         SLOW_EN_BIT   = 6;
   localparam int         SELECT_BIT    = 5;
   // reset values
   localparam logic [7:0] LOWER_RESET   = 8'h00;
   localparam logic [7:0] UPPER_RESET   = 8'h00;
   localparam logic [7:0] CMP_RESET     = 8'h00;
   localparam logic [2:0] SYS_RESET     = 3'h4;
   // bus and compare constants
   localparam logic [2:0] SIZE_WORD     = 3'h2;
   localparam logic       RESP_OKAY     = 1'b0;
   localparam int         CMP_LOW_BITS  = 8;
endpackage : warmup_pkg

//--- hw/reg_access_if.sv
// Purpose: register access between bus port and register file
// Assumes: writes last one cycle, read data is combinational
// Notes:   none
`timescale 1ns/1ps
interface reg_access_if;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr_en;
   logic [31:0] rdata;
   modport bus  (output addr, output wdata, output wr_en, input rdata);
   modport regs (input addr, input wdata, input wr_en, output rdata);
endinterface : reg_access_if

//--- hw/ahb_reg_port.sv
// Purpose: AHB-Lite slave front end for the register file
// Assumes: single word transfers, response always OKAY
// Notes:   writes have no wait state, reads one wait state
`timescale 1ns/1ps
module ahb_reg_port
   import warmup_pkg::*;
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // register file side
   reg_access_if.bus        regs
);
   logic       accept;
   logic       wr_pend_q;
   logic       rd_wait_q;
   logic [7:0] addr_q;

   assign accept = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_q <= 8'h00;
      end else if (accept) begin
         addr_q <= haddr[7:0];
      end
   end

   // narrow writes are dropped rather than merged
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
      end else begin
         wr_pend_q <= accept && hwrite && (hsize == SIZE_WORD);
      end
   end

   // wait state lets a preceding write land before the read samples
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_wait_q <= 1'b0;
         hreadyout <= 1'b1;
      end else begin
         rd_wait_q <= accept && !hwrite;
         hreadyout <= !(accept && !hwrite);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_wait_q) begin
         hrdata <= regs.rdata;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= RESP_OKAY;
      end else begin
         hresp <= RESP_OKAY;
      end
   end

   assign regs.addr  = addr_q;
   assign regs.wdata = hwdata;
   assign regs.wr_en = wr_pend_q;
endmodule : ahb_reg_port

//--- hw/warmup_count.sv
// Purpose: cascaded up-counter with upper-byte compare
// Assumes: tick is a one-cycle pulse on the hclk domain
// Notes:   low compare bits never take part in the match
`timescale 1ns/1ps
module warmup_count
   import warmup_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // control
   input  wire logic             tick,
   input  wire logic             run,
   input  wire logic [7:0]       compare_high,
   // state
   output logic      [WIDTH-1:0] count,
   output logic                  match
);
   logic [WIDTH-1:0] next;
   logic [WIDTH-1:0] target;
   logic             hit;

   if (WIDTH != 2 * CMP_LOW_BITS) begin : g_width_check
      $error("warmup_count: WIDTH must be 16");
   end

   assign next   = count + {{(WIDTH-1){1'b0}}, 1'b1};
   assign target = {compare_high, {CMP_LOW_BITS{1'b0}}};
   assign hit    = (next == target);
   assign match  = run && tick && hit;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
      end else if (!run) begin
         count <= '0;
      end else if (tick) begin
         count <= hit ? '0 : next;
      end
   end
endmodule : warmup_count

//--- hw/warmup_timer.sv
// What this block does
// - once running, count up; on compare match clear count and raise irq
// - slow source gives 256 to 65536 slow ticks of warm-up
// - fast source gives 256 to 65536 fast ticks of warm-up
// - system control two bit 5 selects slow (1) or fast (0) clock
// - system control two bit 7 enables the fast oscillator
// - system control two bit 6 enables the slow oscillator
// - match uses only the compare high byte, low byte ignored
//
// Purpose: oscillator warm-up timer with AHB-Lite registers
// Assumes: clock pins are slow enough to be sampled at hclk
// Notes:   pin clocks are edge-detected, not used as clocks
`timescale 1ns/1ps
module warmup_timer
   import warmup_pkg::*;
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // oscillator clock pins
   input  wire logic        fast_clock,
   input  wire logic        slow_clock,
   // oscillator and clock control
   output logic             fast_osc_enable,
   output logic             slow_osc_enable,
   output logic             slow_clock_select,
   // match event
   output logic             cascade_match_irq
);
   reg_access_if regs_bus ();

   logic [7:0]  lower_timer_control_q;
   logic [7:0]  upper_timer_control_q;
   logic [7:0]  compare_low_byte_q;
   logic [7:0]  compare_high_byte_q;
   logic [1:0]  pin_in;
   logic [1:0]  pin_meta_q;
   logic [1:0]  pin_sync_q;
   logic [1:0]  pin_last_q;
   logic [1:0]  pin_rise;
   logic [2:0]  src_sel;
   logic        mode_ok;
   logic        run;
   logic        tick;
   logic [15:0] count;
   logic        match;
   logic [31:0] rdata_c;

   function automatic logic is_reg(input logic [7:0] a,
                                   input logic [7:0] off);
      is_reg = (a[7:2] == off[7:2]);
   endfunction : is_reg

   function automatic logic wr_to(input logic [7:0] off);
      wr_to = regs_bus.wr_en && is_reg(regs_bus.addr, off);
   endfunction : wr_to

   ahb_reg_port u_port (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hrdata    (hrdata),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .regs      (regs_bus.bus)
   );

   // pin clocks: two-flop synchroniser then rising-edge detect
   assign pin_in = {fast_clock, slow_clock};

   for (genvar i = 0; i < 2; i++) begin : g_pin_sync
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            pin_meta_q[i] <= 1'b0;
            pin_sync_q[i] <= 1'b0;
            pin_last_q[i] <= 1'b0;
         end else begin
            pin_meta_q[i] <= pin_in[i];
            pin_sync_q[i] <= pin_meta_q[i];
            pin_last_q[i] <= pin_sync_q[i];
         end
      end
      assign pin_rise[i] = pin_sync_q[i] && !pin_last_q[i];
   end

   // source and mode decode
   assign src_sel = lower_timer_control_q[SRC_LSB +: 3];
   assign mode_ok = (lower_timer_control_q[2:0] == MODE_CASCADE) &&
                    (upper_timer_control_q[2:0] == MODE_WARMUP);
   assign run     = upper_timer_control_q[RUN_BIT] && mode_ok;
   // other source codes give no tick, so the counter holds
   assign tick    = ((src_sel == SRC_SLOW) && pin_rise[0]) ||
                    ((src_sel == SRC_FAST) && pin_rise[1]);

   warmup_count #(
      .WIDTH (16)
   ) u_count (
      .clk          (hclk),
      .rst_n        (hresetn),
      .tick         (tick),
      .run          (run),
      .compare_high (compare_high_byte_q),
      .count        (count),
      .match        (match)
   );

   // timer registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lower_timer_control_q <= LOWER_RESET;
      end else if (wr_to(OFF_LOWER_CTL)) begin
         lower_timer_control_q <= regs_bus.wdata[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         upper_timer_control_q <= UPPER_RESET;
      end else if (wr_to(OFF_UPPER_CTL)) begin
         upper_timer_control_q <= regs_bus.wdata[7:0];
      end
   end

   // low byte kept for software even though the match ignores it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         compare_low_byte_q  <= CMP_RESET;
         compare_high_byte_q <= CMP_RESET;
      end else begin
         if (wr_to(OFF_CMP_LOW)) begin
            compare_low_byte_q <= regs_bus.wdata[7:0];
         end
         if (wr_to(OFF_CMP_HIGH)) begin
            compare_high_byte_q <= regs_bus.wdata[7:0];
         end
      end
   end

   // second system control: oscillator enables and clock select
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fast_osc_enable   <= SYS_RESET[2];
         slow_osc_enable   <= SYS_RESET[1];
         slow_clock_select <= SYS_RESET[0];
      end else if (wr_to(OFF_SYS_CTL)) begin
         fast_osc_enable   <= regs_bus.wdata[FAST_EN_BIT];
         slow_osc_enable   <= regs_bus.wdata[SLOW_EN_BIT];
         slow_clock_select <= regs_bus.wdata[SELECT_BIT];
      end
   end

   // match request, one cycle per match
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cascade_match_irq <= 1'b0;
      end else begin
         cascade_match_irq <= match;
      end
   end

   // read decode, unmapped words read as zero
   always_comb begin
      rdata_c = 32'h0000_0000;
      if (is_reg(regs_bus.addr, OFF_LOWER_CTL)) begin
         rdata_c[7:0] = lower_timer_control_q;
      end else if (is_reg(regs_bus.addr, OFF_UPPER_CTL)) begin
         rdata_c[7:0] = upper_timer_control_q;
      end else if (is_reg(regs_bus.addr, OFF_CMP_LOW)) begin
         rdata_c[7:0] = compare_low_byte_q;
      end else if (is_reg(regs_bus.addr, OFF_CMP_HIGH)) begin
         rdata_c[7:0] = compare_high_byte_q;
      end else if (is_reg(regs_bus.addr, OFF_SYS_CTL)) begin
         rdata_c[FAST_EN_BIT] = fast_osc_enable;
         rdata_c[SLOW_EN_BIT] = slow_osc_enable;
         rdata_c[SELECT_BIT]  = slow_clock_select;
      end else if (is_reg(regs_bus.addr, OFF_STATUS)) begin
         rdata_c[15:0] = count;
         rdata_c[16]   = run;
         rdata_c[17]   = mode_ok;
      end
   end

   assign regs_bus.rdata = rdata_c;

   // checking helpers
   logic [16:0] ticks_seen_q;
   logic [16:0] span;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ticks_seen_q <= 17'h0_0000;
      end else if (!run || match) begin
         ticks_seen_q <= 17'h0_0000;
      end else if (tick) begin
         ticks_seen_q <= ticks_seen_q + 17'h0_0001;
      end
   end

   // a zero high byte only matches after the count wraps: 65536 ticks
   assign span = {(compare_high_byte_q == 8'h00), compare_high_byte_q, 8'h00};

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_match;
      match;
   endsequence

   sequence s_sys_write;
      wr_to(OFF_SYS_CTL);
   endsequence

   property p_match_clears;
      s_match |=> (count == 16'h0000) && cascade_match_irq;
   endproperty
   a_match_clears: assert property (p_match_clears)
      else $error("match did not clear count or raise irq");

   property p_count_up;
      (run && tick && !match) |=> (count == $past(count) + 16'h0001);
   endproperty
   a_count_up: assert property (p_count_up)
      else $error("counter did not step by one");

   property p_slow_span;
      (s_match and (src_sel == SRC_SLOW))
         |-> (ticks_seen_q + 17'h0_0001 == span);
   endproperty
   a_slow_span: assert property (p_slow_span)
      else $error("slow warm-up span wrong");

   property p_fast_span;
      (s_match and (src_sel == SRC_FAST))
         |-> (ticks_seen_q + 17'h0_0001 == span);
   endproperty
   a_fast_span: assert property (p_fast_span)
      else $error("fast warm-up span wrong");

   property p_low_ignored;
      s_match |-> (count[7:0] == 8'hff);
   endproperty
   a_low_ignored: assert property (p_low_ignored)
      else $error("match not on high byte boundary");

   property p_select;
      s_sys_write |=> (slow_clock_select == $past(regs_bus.wdata[5]));
   endproperty
   a_select: assert property (p_select)
      else $error("clock select not taken from bit 5");

   property p_fast_en;
      s_sys_write |=> (fast_osc_enable == $past(regs_bus.wdata[7]));
   endproperty
   a_fast_en: assert property (p_fast_en)
      else $error("fast enable not taken from bit 7");

   property p_slow_en;
      s_sys_write |=> (slow_osc_enable == $past(regs_bus.wdata[6]));
   endproperty
   a_slow_en: assert property (p_slow_en)
      else $error("slow enable not taken from bit 6");

   property p_stop;
      (!run) [*2] |-> (count == 16'h0000) && !cascade_match_irq;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stopped counter kept count or irq");

   property p_run_stop;
      $fell(run) |=> (count == 16'h0000) && !cascade_match_irq;
   endproperty
   a_run_stop: assert property (p_run_stop)
      else $error("count not cleared right after stop");

   property p_irq_single;
      cascade_match_irq |=> !cascade_match_irq;
   endproperty
   a_irq_single: assert property (p_irq_single)
      else $error("match request held longer than one cycle");
endmodule : warmup_timer

//--- test/warmup_timer_tb.sv
// Purpose: self-checking bench of the oscillator warm-up timer
// Assumes: single slave, hready looped back from hreadyout
// Notes:   pin clocks toggle with two hclk per level, the fastest legal
`timescale 1ns/1ps
module warmup_timer_tb
   import warmup_pkg::*;
;
   // bus and pins
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        fast_clock, slow_clock, cascade_match_irq;
   logic        fast_osc_enable, slow_osc_enable, slow_clock_select;
   // model state
   logic [31:0] seed_q = 32'hbcf9808a;
   logic [7:0]  mreg [0:4];
   int          mcount, m_irq, irq_cnt, error_cnt, n_tests;

   warmup_timer i_warmup_timer (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .fast_clock(fast_clock), .slow_clock(slow_clock),
      .fast_osc_enable(fast_osc_enable),
      .slow_osc_enable(slow_osc_enable),
      .slow_clock_select(slow_clock_select),
      .cascade_match_irq(cascade_match_irq)
   );

   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   // one pulse per match, so a plain count is enough
   always @(posedge hclk) begin
      if (cascade_match_irq === 1'b1) irq_cnt++;
   end

   function logic [31:0] rnd();
      seed_q = {seed_q[30:0], seed_q[31] ^ seed_q[21] ^ seed_q[1] ^ seed_q[0]};
      return seed_q;
   endfunction : rnd

   function automatic logic [31:0] exp_rd(input logic [7:0] a);
      logic ok;
      ok = (mreg[0][2:0] == MODE_CASCADE) && (mreg[1][2:0] == MODE_WARMUP);
      if (a < OFF_STATUS) return {24'h0, mreg[a[4:2]]};
      if (a == OFF_STATUS)
         return {14'h0, ok, ok & mreg[1][RUN_BIT], 16'(mcount)};
      return 32'h0;
   endfunction : exp_rd

   task stop_test();
      $display("mismatches %0d, checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : stop_test

   task chk_reg(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_reg

   task chk_pin(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_pin

   // call just after a rising edge; returns just after one
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            input logic [2:0] sz, output logic [31:0] rd);
      int n;
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      hsize  <= sz;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      rd = hrdata;
      chk_pin(hresp, RESP_OKAY);
      if (n >= 40) begin
         error_cnt++;
         stop_test();
      end
   endtask : bus

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, SIZE_WORD, r);
      if (a < OFF_STATUS)
         mreg[a[4:2]] = (a == OFF_SYS_CTL) ? (d[7:0] & 8'he0) : d[7:0];
   endtask : wr

   task rdchk(input logic [7:0] a);
      logic [31:0] r;
      bus(1'b0, a, rnd(), SIZE_WORD, r);
      chk_reg(r, exp_rd(a));
   endtask : rdchk

   // outputs land on the same edge that completes the write
   task sys_pins();
      @(posedge hclk);
      chk_pin(fast_osc_enable, mreg[4][FAST_EN_BIT]);
      chk_pin(slow_osc_enable, mreg[4][SLOW_EN_BIT]);
      chk_pin(slow_clock_select, mreg[4][SELECT_BIT]);
   endtask : sys_pins

   // extra settle edges cover the three-edge tick delay and the irq
   task pulse(input logic on_slow, input int n);
      repeat (n) begin
         if (on_slow) slow_clock <= 1'b1;
         else fast_clock <= 1'b1;
         repeat (2) @(posedge hclk);
         if (on_slow) slow_clock <= 1'b0;
         else fast_clock <= 1'b0;
         repeat (2) @(posedge hclk);
      end
      repeat (4) @(posedge hclk);
   endtask : pulse

   task run(input logic on_slow, input logic [7:0] hi);
      int n;
      n = int'(hi) * 256;
      wr(OFF_SYS_CTL, on_slow ? 32'hc0 : 32'he0);
      sys_pins();
      wr(OFF_LOWER_CTL, on_slow ? 32'h43 : 32'h63);
      wr(OFF_UPPER_CTL, 32'h05);
      wr(OFF_CMP_LOW, rnd());
      wr(OFF_CMP_HIGH, {24'h0, hi});
      wr(OFF_UPPER_CTL, 32'h0d);
      pulse(!on_slow, 20);
      rdchk(OFF_STATUS);
      pulse(on_slow, n - 1);
      mcount = n - 1;
      rdchk(OFF_STATUS);
      chk_reg(irq_cnt, m_irq);
      pulse(on_slow, 1);
      mcount = 0;
      m_irq++;
      chk_reg(irq_cnt, m_irq);
      rdchk(OFF_STATUS);
      pulse(on_slow, 7);
      mcount = 7;
      rdchk(OFF_STATUS);
      wr(OFF_UPPER_CTL, 32'h05);
      mcount = 0;
      rdchk(OFF_STATUS);
      wr(OFF_SYS_CTL, on_slow ? 32'he0 : 32'hc0);
      sys_pins();
      wr(OFF_SYS_CTL, on_slow ? 32'h60 : 32'h80);
      sys_pins();
      pulse(on_slow, 300);
      chk_reg(irq_cnt, m_irq);
      rdchk(OFF_STATUS);
   endtask : run

   initial begin
      hresetn    = 1'b0;
      hsel       = 1'b0;
      htrans     = 2'h0;
      haddr      = 32'h0;
      hwrite     = 1'b0;
      hsize      = SIZE_WORD;
      hwdata     = 32'h0;
      fast_clock = 1'b0;
      slow_clock = 1'b0;
      irq_cnt    = 0;
      m_irq      = 0;
      mcount     = 0;
      error_cnt  = 0;
      n_tests    = 0;
      mreg = '{LOWER_RESET, UPPER_RESET, CMP_RESET, CMP_RESET,
               {SYS_RESET, 5'h0}};
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      sys_pins();
      for (int a = 0; a < 32; a += 4) rdchk(8'(a));
      // random contents, status read-only, unmapped reads zero
      for (int a = 0; a < 32; a += 4) begin
         wr(8'(a), rnd());
         rdchk(8'(a));
      end
      // byte-sized writes are dropped
      bus(1'b1, OFF_CMP_HIGH, 32'h5a, 3'h0, v);
      rdchk(OFF_CMP_HIGH);
      for (int i = 0; i < 8; i++) begin
         wr(OFF_SYS_CTL, {24'h0, 3'(i), 5'h1f});
         sys_pins();
      end
      run(1'b1, 8'h01);
      run(1'b0, 8'h02);
      // source codes other than slow or fast give no ticks
      wr(OFF_LOWER_CTL, 32'h53);
      wr(OFF_UPPER_CTL, 32'h0d);
      pulse(1'b1, 10);
      pulse(1'b0, 10);
      rdchk(OFF_STATUS);
      chk_reg(irq_cnt, m_irq);
      stop_test();
   end
endmodule : warmup_timer_tb
